/* File: bench/brc_host.sv */
// register master model standing in for the configuring host
// assumes the slave answers with waitrequest low for one cycle
`timescale 1ns/10ps
module brc_host (
    // clock
    input  wire logic        clk,
    // avalon-mm master side
    output logic [7:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    output logic [3:0]       avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    // idle bus from time zero
    initial
    begin
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hF;
    end
    // one access, entered just after a rising edge
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        // waitrequest is sampled at each rising edge; only the bench watchdog ends a hang
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        // read data stands at the same edge as the answer
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        // one edge passes so the next request is not set in this step
        @(posedge clk);
    endtask
endmodule

/* File: bench/brc_monitor.sv */
// concurrent checks on the ports of the control block
// assumes one clock domain with a synchronous reset
`timescale 1ns/10ps
module brc_monitor
    import brc_pkg::*;
#(
    parameter int STEP_CYCLES = RAMP_STEP_CYCLES,
    parameter int GAP_CYCLES  = OFF_GAP_CYCLES
)(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic [1:0] otp_phase_config,
    input wire logic [7:0] first_buck_ref,
    input wire logic [7:0] second_buck_ref,
    input wire logic [3:0] regulator_mode_sel,
    input wire logic [1:0] buck_on,
    input wire logic       second_track_first,
    input wire logic       dual_phase,
    input wire logic [5:0] switching_phase_sel,
    input wire logic       irq_pin_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // first cycle of a bus request
    sequence s_req;
        $rose(avs_read || avs_write);
    endsequence
    // first buck held off for a few cycles
    sequence s_off1;
        (regulator_mode_sel[1:0] == MODE_OFF) [*4];
    endsequence
    AST_WAIT_ONE: assert property (s_req |=> !avs_waitrequest)
        else $error("answer not one cycle after request");
    AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held longer than one cycle");
    AST_PHASE_DEFAULT: assert property ($fell(reset) |-> switching_phase_sel == 6'h3F)
        else $error("phase not zero degrees after reset");
    AST_DUAL: assert property (!$past(reset)
        |-> dual_phase == $past(otp_phase_config == CONFIG_DUAL))
        else $error("dual phase does not follow strap");
    AST_OFF_STOPS: assert property (s_off1 |-> !buck_on[0])
        else $error("first buck running with mode off");
    AST_IRQ_HOLD: assert property (!irq_pin_n && !avs_write && !$past(avs_write)
        && !$past(avs_write, 2) |=> !irq_pin_n)
        else $error("irq pin released without a register write");
    AST_TRACK_STILL: assert property (second_track_first && $past(second_track_first)
        |-> $stable(second_buck_ref))
        else $error("second reference moves while tracking");
    // while running, the first reference in the linear range moves one code at a time
    AST_RAMP_STEP: assert property ($changed(first_buck_ref) && buck_on[0]
        && $past(buck_on[0]) && first_buck_ref != SP_HIGH && $past(first_buck_ref) != SP_HIGH
        |-> first_buck_ref == $past(first_buck_ref) + 8'h01
        || first_buck_ref == $past(first_buck_ref) - 8'h01)
        else $error("first reference jumped while running");
    // a move of the first reference to or from the high code only happens across an off period
    AST_HIGH_VIA_OFF: assert property ($changed(first_buck_ref) && (first_buck_ref == SP_HIGH
        || $past(first_buck_ref) == SP_HIGH) |-> !(buck_on[0] && $past(buck_on[0])))
        else $error("high code crossed without turning off");
endmodule
bind brc_top brc_monitor #(.STEP_CYCLES(STEP_CYCLES), .GAP_CYCLES(GAP_CYCLES)) mon (.*);

/* File: bench/tb.sv */
// self-checking bench for the buck regulator control block
// assumes the host model in brc_host and the bound port monitor
`timescale 1ns/10ps
module tb;
    import brc_pkg::*;
    // configuration word and the fields it should drive
    typedef struct {logic [31:0] d; logic [3:0] il; logic [5:0] ph;} brc_row_t;
    logic        clk, reset, standby_req, same_slot, otp_termination_pulldown;
    logic [1:0]  otp_phase_config, in_power_up_seq, buck_on, buck_pulldown;
    logic [15:0] otp_voltage_default;
    logic [3:0]  otp_inductor_sel, regulator_mode_sel, current_limit_sel, avs_byteenable;
    logic [7:0]  avs_address, first_buck_ref, second_buck_ref;
    logic        avs_read, avs_write, avs_waitrequest, second_track_first, dual_phase, irq_pin_n;
    logic [31:0] avs_writedata, avs_readdata;
    logic [5:0]  switching_phase_sel;
    logic [1:0]  mseq [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    brc_row_t    rows [4] = '{'{32'h000, 4'h0, 6'h00}, '{32'h175, 4'h5, 6'h0F},
                              '{32'h62E, 4'hE, 6'h32}, '{32'h77B, 4'hB, 6'h3F}};
    int          error_cnt = 0;
    int          comparisons = 0;
    // short counts keep ramps brief
    brc_top #(.STEP_CYCLES(2), .GAP_CYCLES(3)) dut (.*);
    brc_host host (.*);
    always #2 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.acc(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        host.acc(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    // output picked by a small index, so one wait serves all
    function automatic logic [31:0] pick(input int s);
        case (s)
            0: pick = first_buck_ref;
            1: pick = second_track_first;
            2: pick = buck_pulldown;
            3: pick = irq_pin_n;
            4: pick = regulator_mode_sel;
            5: pick = buck_on;
            6: pick = second_buck_ref;
            default: pick = dual_phase;
        endcase
    endfunction
    // bounded wait, sampled mid cycle; ends just after a rising edge
    task automatic await(input int s, input logic [31:0] e);
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (pick(s) !== e && n < 2000);
        chk(pick(s), e);
        @(posedge clk);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog: the whole run needs far fewer cycles than this
    initial
    begin
        #200000;
        error_cnt++;
        stop_test();
    end
    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        standby_req = 1'b0;
        same_slot = 1'b0;
        otp_termination_pulldown = 1'b1;
        otp_phase_config = 2'b00;
        in_power_up_seq = 2'b01;
        otp_voltage_default = 16'h0850;
        otp_inductor_sel = 4'h6;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(switching_phase_sel, 6'h3F);
        chk(irq_pin_n, 1'b1);
        @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        rd(REG_RUN_SP, 32'h0850);
        rd(REG_STBY_SP, 32'h0850);
        rd(REG_MODE, 32'h33);
        rd(REG_OTP, 32'h8006);
        rd(8'h1C, 32'h0);
        wr(REG_IRQ, 32'h3);
        $display("defaults done");
        foreach (rows[i])
        begin
            wr(REG_CFG, rows[i].d);
            rd(REG_CFG, rows[i].d);
            @(negedge clk);
            chk(current_limit_sel, rows[i].il);
            chk(switching_phase_sel, rows[i].ph);
            @(posedge clk);
        end
        $display("config rows done");
        foreach (mseq[i])
        begin
            wr(REG_MODE, 32'h30 | 32'(mseq[i]));
            await(4, {2'b00, mseq[i]});
            await(3, 1'b0);
            rd(REG_IRQ, 32'h1);
            wr(REG_IRQ, 32'h1);
            await(3, 1'b1);
        end
        await(5, 2'b00);
        wr(REG_IRQ, 32'h100);
        wr(REG_MODE, 32'h31);
        await(4, 4'h1);
        await(3, 1'b1);
        rd(REG_IRQ, 32'h101);
        wr(REG_IRQ, 32'h1);
        $display("modes and irq done");
        await(0, 8'h50);
        wr(REG_RUN_SP, 32'h08B2);
        rd(REG_RUN_SP, 32'h0850);
        wr(REG_RUN_SP, 32'h08B1);
        await(0, 8'hB1);
        wr(REG_RUN_SP, 32'h0850);
        await(0, 8'h50);
        wr(REG_STBY_SP, 32'h084C);
        standby_req <= 1'b1;
        await(0, 8'h4C);
        await(4, 4'h3);
        standby_req <= 1'b0;
        await(0, 8'h50);
        $display("set points done");
        wr(REG_MODE, 32'h35);
        wr(REG_CFG, 32'h1000);
        await(1, 1'b1);
        await(6, 8'h08);
        rd(REG_STATUS, 32'h002F0850);
        wr(REG_MODE, 32'h34);
        await(2, 2'b11);
        @(negedge clk);
        chk(buck_on, 2'b00);
        chk(second_track_first, 1'b1);
        @(posedge clk);
        wr(REG_MODE, 32'h35);
        await(0, 8'h50);
        await(1, 1'b1);
        // second alone off: the strap picks pull-down or high impedance
        wr(REG_MODE, 32'h31);
        await(2, 2'b10);
        otp_termination_pulldown <= 1'b0;
        await(2, 2'b00);
        // same slot: tracking must start without a ramp
        same_slot <= 1'b1;
        wr(REG_MODE, 32'h35);
        repeat (2) @(negedge clk);
        chk(second_track_first, 1'b1);
        @(posedge clk);
        $display("termination done");
        otp_phase_config <= 2'b01;
        await(7, 1'b1);
        $display("dual phase done");
        // reset in mid run restores defaults
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        rd(REG_CFG, 32'h770);
        rd(REG_RUN_SP, 32'h0850);
        $display("second reset done");
        stop_test();
    end
endmodule

/* File: hw/brc_channel.sv */
// one buck regulator set point sequencer: ramps, 1.8 V off gap, tracking
// assumes target and enable come from logic on the same clock
`timescale 1ns/10ps
module brc_channel
    import brc_pkg::*;
#(
    parameter int STEP_CYCLES = RAMP_STEP_CYCLES,
    parameter int GAP_CYCLES  = OFF_GAP_CYCLES
)(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // control
    input  wire logic       enable,      // regulator mode not off
    input  wire logic [7:0] target,      // selected valid set point code
    input  wire logic       no_ramp,     // jump straight to target
    input  wire logic       track_req,   // follow the first buck once settled
    // state
    output logic [7:0]      level,       // reference code now applied
    output logic            on,          // power stage running
    output logic            settled,     // level reached target; stays set while ramping on from hold
    output logic            tracking     // reference taken from first buck
);
    typedef struct packed {
        brc_rstate_t st;
        logic [7:0]  lvl;
        logic [15:0] cnt;
    } brc_ch_t;
    brc_ch_t s_q, s_d;   // full channel state

    // ramp toward target one code per step; 1.8 V crossings go through the gap
    always_comb
    begin
        s_d = s_q;
        case (s_q.st)
            BRC_OFF:
            begin
                s_d.cnt = '0;
                if (enable)
                begin
                    s_d.lvl = (target == SP_HIGH || no_ramp) ? target : 8'h00;
                    s_d.st  = BRC_RAMP;
                end
            end
            BRC_RAMP, BRC_HOLD:
            begin
                if (!enable)
                    s_d.st = BRC_OFF;
                else if ((target == SP_HIGH) != (s_q.lvl == SP_HIGH))
                begin
                    s_d.st  = BRC_GAP;
                    s_d.cnt = '0;
                end
                else if (s_q.lvl == target)
                    s_d.st = track_req ? BRC_TRACK : BRC_HOLD;
                else if (no_ramp)
                    s_d.lvl = target;
                else if (s_q.cnt == 16'(STEP_CYCLES - 1))
                begin
                    s_d.cnt = '0;
                    s_d.lvl = (s_q.lvl < target) ? s_q.lvl + 8'h01 : s_q.lvl - 8'h01;
                end
                else
                    s_d.cnt = s_q.cnt + 16'h0001;
            end
            BRC_GAP:
            begin
                if (!enable)
                    s_d.st = BRC_OFF;
                else if (s_q.cnt == 16'(GAP_CYCLES - 1))
                begin
                    s_d.lvl = target;
                    s_d.st  = BRC_RAMP;
                    s_d.cnt = '0;
                end
                else
                    s_d.cnt = s_q.cnt + 16'h0001;
            end
            BRC_TRACK:
            begin
                s_d.lvl = target;
                if (!enable)
                    s_d.st = BRC_OFF;
                else if (!track_req)
                    s_d.st = BRC_HOLD;
            end
            default:
                s_d.st = BRC_OFF;
        endcase
        if (reset)
        begin
            s_d.st  = BRC_OFF;
            s_d.lvl = '0;
            s_d.cnt = '0;
        end
    end

    // register the channel state
    always_ff @(posedge clk)
        s_q <= s_d;

    assign level    = s_q.lvl;
    assign on       = (s_q.st != BRC_OFF) && (s_q.st != BRC_GAP);
    assign settled  = (s_q.st == BRC_HOLD) || (s_q.st == BRC_TRACK);
    assign tracking = (s_q.st == BRC_TRACK);
endmodule

/* File: hw/brc_pkg.sv */
// constants, types and field layout of the buck regulator control block
// assumes a single 250 MHz clock domain and an avalon-mm register master
package brc_pkg;
    // register byte offsets
    localparam logic [7:0] REG_RUN_SP    = 8'h00; // run set points, one byte each buck
    localparam logic [7:0] REG_STBY_SP   = 8'h04; // standby set points
    localparam logic [7:0] REG_MODE      = 8'h08; // run/stby mode fields
    localparam logic [7:0] REG_CFG       = 8'h0C; // limit, phase, termination enable
    localparam logic [7:0] REG_IRQ       = 8'h10; // sticky irq, mask (write one clears)
    localparam logic [7:0] REG_STATUS    = 8'h14; // active set point and control state
    localparam logic [7:0] REG_OTP       = 8'h18; // otp fields, read only
    // field positions in REG_CFG and REG_IRQ
    localparam int CFG_ILIM0  = 0;
    localparam int CFG_ILIM1  = 2;
    localparam int CFG_PHS0   = 4;
    localparam int CFG_PHS1   = 8;
    localparam int CFG_TERM   = 12;
    localparam int IRQ_MASK0  = 8;
    // codes
    localparam logic [7:0] SP_MAX_LINEAR = 8'hB0; // 1.50000 V
    localparam logic [7:0] SP_HIGH       = 8'hB1; // 1.80000 V
    localparam logic [1:0] MODE_OFF      = 2'h0;
    localparam logic [1:0] MODE_PWM      = 2'h1;
    localparam logic [1:0] MODE_PFM      = 2'h2;
    localparam logic [1:0] MODE_SKIP     = 2'h3;
    localparam logic [2:0] PHASE_RESET   = 3'h7;  // zero degrees
    localparam logic [1:0] ILIM_RESET    = 2'h0;
    localparam logic [1:0] CONFIG_SINGLE = 2'h0;
    localparam logic [1:0] CONFIG_DUAL   = 2'h1;
    // ramp step timing: one 6.25 mV step per this many ns
    localparam int RAMP_STEP_NS     = 400;
    localparam int CLK_PERIOD_NS    = 4;
    localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OFF_GAP_NS       = 1000;   // off time on a 1.8 V crossing
    localparam int OFF_GAP_CYCLES   = (OFF_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // per-regulator ramp states
    typedef enum logic [2:0] {BRC_OFF, BRC_RAMP, BRC_HOLD, BRC_GAP, BRC_TRACK} brc_rstate_t;
endpackage

/* File: hw/brc_top.sv */
// buck regulator control: registers, mode control, termination mode, irq
// assumes avalon-mm master on clk; otp and sequencing straps are static pins
`timescale 1ns/10ps
module brc_top
    import brc_pkg::*;
#(
    parameter int STEP_CYCLES = RAMP_STEP_CYCLES,
    parameter int GAP_CYCLES  = OFF_GAP_CYCLES
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // otp and sequencing inputs (pins)
    input  wire logic [15:0] otp_voltage_default,      // byte per buck
    input  wire logic [3:0]  otp_inductor_sel,         // two bits per buck
    input  wire logic        otp_termination_pulldown,
    input  wire logic [1:0]  otp_phase_config,
    input  wire logic [1:0]  in_power_up_seq,          // buck is in the sequence
    input  wire logic        same_slot,                // second buck starts with first
    input  wire logic        standby_req,              // system standby state
    // regulator controls
    output logic [7:0]       first_buck_ref,
    output logic [7:0]       second_buck_ref,
    output logic [3:0]       regulator_mode_sel,      // two bits per buck
    output logic [1:0]       buck_on,
    output logic [1:0]       buck_pulldown,
    output logic             second_track_first,
    output logic             dual_phase,
    output logic [3:0]       current_limit_sel,
    output logic [5:0]       switching_phase_sel,
    output logic             irq_pin_n
);
    typedef struct packed {
        logic [1:0][7:0] run_sp;       // run_setpoint per buck
        logic [1:0][7:0] stby_sp;      // standby_setpoint per buck
        logic [1:0][1:0] run_mode;     // run_state_mode_sel
        logic [1:0][1:0] stby_mode;    // standby_state_mode_sel
        logic [1:0][1:0] ilim;         // current_limit_sel
        logic [1:0][2:0] phase;        // switching_phase_sel
        logic            term_en;      // termination_mode_en
        logic [1:0]      irq;          // mode_change_irq, sticky
        logic [1:0]      mask;         // irq mask
        logic [1:0][1:0] mode_prev;    // last applied mode
        logic            loaded;       // otp defaults taken
        logic            ack;          // bus answer this cycle
        logic [31:0]     rdata;
        logic [1:0]      stby_m, stby_s; // standby synchroniser
        logic [1:0][1:0] out_mode;
        logic [1:0][7:0] out_ref;
        logic [1:0]      out_on, out_pd;
        logic            out_trk, out_irq_n, out_dual;
    } brc_state_t;
    brc_state_t r_q, r_d;

    logic [1:0][7:0] lvl;      // channel levels
    logic [1:0]      ch_on;    // channel running
    logic [1:0]      ch_set;   // channel settled
    logic [1:0]      ch_trk;   // channel tracking
    logic [1:0][7:0] tgt;      // selected targets
    logic [1:0]      en;       // channel enables
    logic            dual;     // dual phase strap

    assign dual = (otp_phase_config == CONFIG_DUAL);
    // state selects set point and mode; dual phase runs both from the first's registers
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            int j;
            j = dual ? 0 : i;
            tgt[i] = r_q.stby_s[1] ? r_q.stby_sp[j] : r_q.run_sp[j];
            en[i]  = (r_q.stby_s[1] ? r_q.stby_mode[j] : r_q.run_mode[j]) != MODE_OFF;
        end
    end

    // sequencers; the second one jumps (no ramping) in tracking mode with same_slot while the first runs
    brc_channel #(.STEP_CYCLES(STEP_CYCLES), .GAP_CYCLES(GAP_CYCLES)) u_first
    (
        .clk       (clk),
        .reset     (reset),
        .enable    (en[0] && r_q.loaded),
        .target    (tgt[0]),
        .no_ramp   (1'b0),
        .track_req (1'b0),
        .level     (lvl[0]),
        .on        (ch_on[0]),
        .settled   (ch_set[0]),
        .tracking  (ch_trk[0])
    );
    brc_channel #(.STEP_CYCLES(STEP_CYCLES), .GAP_CYCLES(GAP_CYCLES)) u_second
    (
        .clk       (clk),
        .reset     (reset),
        // stays enabled while the first is off, so tracking survives the discharge
        .enable    (en[1] && r_q.loaded),
        .target    (tgt[1]),
        .no_ramp   (r_q.term_en && same_slot && ch_on[0]),
        .track_req (r_q.term_en && !dual),
        .level     (lvl[1]),
        .on        (ch_on[1]),
        .settled   (ch_set[1]),
        .tracking  (ch_trk[1])
    );

    // registers, bus, interrupt and output staging
    always_comb
    begin
        logic [1:0][1:0] cur_mode;
        logic [31:0]     wd;
        logic            hit;
        cur_mode = '0;
        wd       = avs_writedata;
        hit      = 1'b0;
        r_d      = r_q;
        r_d.ack  = 1'b0;
        r_d.stby_m = {r_q.stby_m[0], standby_req};
        r_d.stby_s = {r_q.stby_s[0], r_q.stby_m[1]};
        // otp defaults once after reset release
        if (!r_q.loaded)
        begin
            r_d.loaded = 1'b1;
            for (int i = 0; i < 2; i++)
            begin
                r_d.run_sp[i]    = otp_voltage_default[i*8 +: 8];
                r_d.stby_sp[i]   = otp_voltage_default[i*8 +: 8];
                r_d.run_mode[i]  = in_power_up_seq[i] ? MODE_SKIP : MODE_OFF;
                r_d.stby_mode[i] = in_power_up_seq[i] ? MODE_SKIP : MODE_OFF;
            end
        end
        // one wait cycle then acknowledge
        if ((avs_read || avs_write) && !r_q.ack)
        begin
            r_d.ack = 1'b1;
            hit = 1'b1;
        end
        if (hit && avs_write)
        begin
            case (avs_address)
                REG_RUN_SP, REG_STBY_SP:
                    for (int i = 0; i < 2; i++)
                        if (avs_byteenable[i] && wd[i*8 +: 8] <= SP_HIGH)
                        begin
                            if (avs_address == REG_RUN_SP)
                                r_d.run_sp[i] = wd[i*8 +: 8];
                            else
                                r_d.stby_sp[i] = wd[i*8 +: 8];
                        end
                REG_MODE:
                    if (avs_byteenable[0])
                    begin
                        r_d.run_mode  = wd[3:0];
                        r_d.stby_mode = wd[7:4];
                    end
                REG_CFG:
                begin
                    if (avs_byteenable[0])
                    begin
                        r_d.ilim     = {wd[CFG_ILIM1 +: 2], wd[CFG_ILIM0 +: 2]};
                        r_d.phase[0] = wd[CFG_PHS0 +: 3];
                    end
                    if (avs_byteenable[1])
                    begin
                        r_d.phase[1] = wd[CFG_PHS1 +: 3];
                        r_d.term_en  = wd[CFG_TERM];
                    end
                end
                REG_IRQ:
                begin
                    if (avs_byteenable[0])
                        r_d.irq = r_q.irq & ~wd[1:0];
                    if (avs_byteenable[1])
                        r_d.mask = wd[IRQ_MASK0 +: 2];
                end
                default: ;
            endcase
        end
        if (hit && avs_read)
        begin
            case (avs_address)
                REG_RUN_SP:  r_d.rdata = {16'h0000, r_q.run_sp};
                REG_STBY_SP: r_d.rdata = {16'h0000, r_q.stby_sp};
                REG_MODE:    r_d.rdata = {24'h000000, r_q.stby_mode, r_q.run_mode};
                REG_CFG:     r_d.rdata = {19'h00000, r_q.term_en, 1'b0, r_q.phase[1],
                                          1'b0, r_q.phase[0], r_q.ilim};
                REG_IRQ:     r_d.rdata = {22'h000000, r_q.mask, 6'h00, r_q.irq};
                REG_STATUS:  r_d.rdata = {10'h000, ch_trk[1], r_q.stby_s[1], ch_set, ch_on,
                                          lvl};
                REG_OTP:     r_d.rdata = {16'h0000, otp_termination_pulldown,
                                          9'h000, otp_phase_config, otp_inductor_sel};
                default:     r_d.rdata = 32'h00000000;
            endcase
        end
        // applied mode per buck; change sets sticky irq, set wins over clear
        for (int i = 0; i < 2; i++)
        begin
            cur_mode[i] = (r_q.stby_s[1] ? r_q.stby_mode[dual ? 0 : i]
                                         : r_q.run_mode[dual ? 0 : i]);
            if (!r_q.loaded)
                cur_mode[i] = MODE_OFF;
            if (r_q.loaded && cur_mode[i] != r_q.mode_prev[i])
                r_d.irq[i] = 1'b1;
        end
        r_d.mode_prev = cur_mode;
        r_d.out_irq_n = !(|(r_d.irq & ~r_d.mask));
        // outputs: applied mode codes go to the pins unchanged
        r_d.out_mode = cur_mode;
        r_d.out_ref  = lvl;
        r_d.out_on   = ch_on;
        r_d.out_trk  = ch_trk[1];
        r_d.out_dual = dual;
        // first off in termination mode discharges both; second alone follows otp
        r_d.out_pd[0] = !ch_on[0];
        if (r_q.term_en && !ch_on[0])
        begin
            // both rails discharge together; the second power stage is held off
            r_d.out_pd[1] = 1'b1;
            r_d.out_on[1] = 1'b0;
        end
        else
            r_d.out_pd[1] = !ch_on[1] && (otp_termination_pulldown || !r_q.term_en);
        if (reset)
        begin
            r_d = '0;
            r_d.phase     = {PHASE_RESET, PHASE_RESET};
            r_d.ilim      = {ILIM_RESET, ILIM_RESET};
            r_d.out_irq_n = 1'b1;
            r_d.stby_m    = '0;
        end
    end

    // register everything
    always_ff @(posedge clk)
        r_q <= r_d;

    assign avs_readdata       = r_q.rdata;
    assign avs_waitrequest    = !r_q.ack;
    assign first_buck_ref     = r_q.out_ref[0];
    assign second_buck_ref    = r_q.out_ref[1];
    assign regulator_mode_sel = r_q.out_mode;
    assign buck_on            = r_q.out_on;
    assign buck_pulldown      = r_q.out_pd;
    assign second_track_first = r_q.out_trk;
    assign dual_phase         = r_q.out_dual;
    assign current_limit_sel  = r_q.ilim;
    assign switching_phase_sel = r_q.phase;
    assign irq_pin_n          = r_q.out_irq_n;
endmodule
